// ===== design/ugc_pkg.sv
// Package for the USB global control bits: register layout, reset values, timing.
// Assumes a 100 MHz controller clock shared by both ends.
package ugc_pkg;
  // Bit positions within the 8-bit global control register.
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_SUSP_CLK_BIT = 6;
  localparam int CTL_RWU_SEND_BIT = 5;
  localparam int CTL_DETACH_BIT = 4;
  localparam int CTL_UP_RESUME_BIT = 3;
  localparam int CTL_RWU_ENABLE_BIT = 2;
  localparam int CTL_CONFIGURED_BIT = 1;
  localparam int CTL_ADDR_EN_BIT = 0;
  // Value of the control register after reset.
  localparam logic [7:0] CTL_RESET = 8'h00;
  // Bits that firmware may write; resume status is read only.
  localparam logic [7:0] CTL_WRITE_MASK = 8'hf7;
  // Default function address used before the address is enabled.
  localparam logic [6:0] DEFAULT_ADDR = 7'h00;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  // Clock rate and the least suspend time before resume may be sent.
  localparam int CLK_HZ = 100_000_000;
  localparam int SUSPEND_MIN_US = 5000;
  localparam int SUSPEND_MIN_CYC = (CLK_HZ / 1_000_000) * SUSPEND_MIN_US;
  // Bus reset is an SE0 of about 2.7 us; the least time rounds up to cycles.
  localparam int BUS_RESET_NS = 2700;
  localparam int BUS_RESET_CYC = (BUS_RESET_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Length of the upstream resume signalling driven by the device.
  localparam int RESUME_DRIVE_CYC = 16;
  localparam int CNT_W = 24;
endpackage

// ===== design/ugc_if.sv
// Interface joining firmware end and device end of the USB global control bits.
// Assumes both ends share ref_clk_i; line inputs come from an outside pin model.
`timescale 1ns/1ps
`default_nettype none
interface ugc_if;
  // Firmware write strobe with data, and readback of the register.
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  // Wake flag and its clear strobe.
  logic wake_cpu;
  logic wake_clr;
  // Programmed function address.
  logic [6:0] prog_addr;
  modport dev (input wr_en, input wr_data, output rd_data, output wake_cpu,
    input wake_clr, input prog_addr);
  modport fw (output wr_en, output wr_data, input rd_data, input wake_cpu,
    output wake_clr, output prog_addr);
endinterface
`default_nettype wire

// ===== design/ugc_device.sv
// Device end: holds the global control register and sequences suspend, resume,
// detach and bus reset. Assumes line state inputs arrive from pins, unsynchronised.
// Operation
// - Wake-send bit raises internal wake request
// - Resume only when enabled, clocked, suspended 5ms
// - Detach floats pull-up, else drive 3.3V
// - Resume status set on send while enabled
// - Resume status clears after resume signalling ends
// - Firmware sets configured after nonzero configuration
// - Firmware clears configured on zero configuration
// - Configured cleared by reset and bus reset
// - Firmware sets address enable after set-address
// - Address enable cleared only by resets
// - Default address used while address disabled
// - Enable low resets controller, transceiver, clocks
// - Host resume while suspended sets wake flag
`timescale 1ns/1ps
`default_nettype none
module ugc_device
  import ugc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  ugc_if.dev bus,
  input wire logic line_se0_i,
  input wire logic line_idle_i,
  output logic vref_o,
  output logic vref_oe_o,
  output logic ctrl_clk_en_o,
  output logic xcvr_en_o,
  output logic ctrl_rst_o,
  output logic wake_req_o,
  output logic resume_drive_o,
  output logic [6:0] func_addr_o
);
  import ugc_pkg::*;

  typedef enum logic [1:0] {RS_IDLE, RS_DRIVE, RS_DONE} ugc_rs_t;

  logic [1:0] se0_sync_ff;
  logic [1:0] idle_sync_ff;
  logic [7:0] ctl_ff, nxt_ctl;
  logic [CNT_W-1:0] susp_cnt_ff, nxt_susp_cnt;
  logic [CNT_W-1:0] se0_cnt_ff, nxt_se0_cnt;
  logic [CNT_W-1:0] drv_cnt_ff, nxt_drv_cnt;
  ugc_rs_t rs_ff, nxt_rs;
  logic wake_ff, nxt_wake;
  logic bus_rst_ff, nxt_bus_rst;
  logic vref_ff, nxt_vref;
  logic clk_en_ff, nxt_clk_en;
  logic xcvr_ff, nxt_xcvr;
  logic crst_ff, nxt_crst;
  logic wreq_ff, nxt_wreq;
  logic drv_ff, nxt_drv;
  logic [6:0] addr_ff, nxt_addr;
  logic suspended;
  logic resume_ok;

  // Two-flop synchronisers for the line state pins.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      se0_sync_ff <= 2'h0;
      idle_sync_ff <= 2'h0;
    end else begin
      se0_sync_ff <= {se0_sync_ff[0], line_se0_i};
      idle_sync_ff <= {idle_sync_ff[0], line_idle_i};
    end
  end

  // Suspend is a long idle; bus reset is a long SE0.
  assign suspended = (susp_cnt_ff >= CNT_W'(SUSPEND_MIN_CYC));
  assign resume_ok = ctl_ff[CTL_RWU_ENABLE_BIT] && !ctl_ff[CTL_SUSP_CLK_BIT]
    && ctl_ff[CTL_ENABLE_BIT] && suspended;

  // Next-state logic for the register, counters and resume sequencer.
  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_susp_cnt = susp_cnt_ff;
    nxt_se0_cnt = se0_cnt_ff;
    nxt_drv_cnt = drv_cnt_ff;
    nxt_rs = rs_ff;
    nxt_wake = wake_ff;
    nxt_bus_rst = 1'b0;
    // Idle time counts even with the clock gated, so resume detect stays live.
    if (idle_sync_ff[1] && !drv_ff) begin
      if (!suspended) begin
        nxt_susp_cnt = susp_cnt_ff + CNT_W'(1);
      end
    end else begin
      nxt_susp_cnt = '0;
    end
    if (se0_sync_ff[1]) begin
      if (se0_cnt_ff < CNT_W'(BUS_RESET_CYC)) begin
        nxt_se0_cnt = se0_cnt_ff + CNT_W'(1);
      end
    end else begin
      nxt_se0_cnt = '0;
    end
    if (se0_cnt_ff == CNT_W'(BUS_RESET_CYC - 1)) begin
      nxt_bus_rst = 1'b1;
    end
    // Firmware write; the resume status bit is kept by hardware.
    if (bus.wr_en) begin
      nxt_ctl = (bus.wr_data & CTL_WRITE_MASK) | (ctl_ff & ~CTL_WRITE_MASK);
    end
    // Resume sequencer.
    case (rs_ff)
      RS_IDLE: begin
        if (ctl_ff[CTL_RWU_SEND_BIT] && ctl_ff[CTL_RWU_ENABLE_BIT]) begin
          nxt_ctl[CTL_UP_RESUME_BIT] = 1'b1;
          if (resume_ok) begin
            nxt_rs = RS_DRIVE;
            nxt_drv_cnt = '0;
          end
        end
      end
      RS_DRIVE: begin
        nxt_ctl[CTL_UP_RESUME_BIT] = 1'b1;
        nxt_drv_cnt = drv_cnt_ff + CNT_W'(1);
        if (drv_cnt_ff == CNT_W'(RESUME_DRIVE_CYC - 1)) begin
          nxt_rs = RS_DONE;
        end
      end
      RS_DONE: begin
        nxt_ctl[CTL_UP_RESUME_BIT] = 1'b0;
        if (!ctl_ff[CTL_RWU_SEND_BIT]) begin
          nxt_rs = RS_IDLE;
        end
      end
      default: nxt_rs = RS_IDLE;
    endcase
    // Host non-idle signal while suspended wakes the CPU; set beats clear.
    if (bus.wake_clr) begin
      nxt_wake = 1'b0;
    end
    if (suspended && !idle_sync_ff[1] && rs_ff == RS_IDLE) begin
      nxt_wake = 1'b1;
    end
    // Bus reset clears configured and address enable flags.
    if (bus_rst_ff) begin
      nxt_ctl[CTL_CONFIGURED_BIT] = 1'b0;
      nxt_ctl[CTL_ADDR_EN_BIT] = 1'b0;
    end
    // Disabling the controller idles the resume sequencer and clears resume status.
    if (!ctl_ff[CTL_ENABLE_BIT]) begin
      nxt_rs = RS_IDLE;
      nxt_ctl[CTL_UP_RESUME_BIT] = 1'b0;
    end
  end

  // Next values of the outputs.
  always_comb begin
    nxt_vref = !ctl_ff[CTL_DETACH_BIT];
    nxt_clk_en = ctl_ff[CTL_ENABLE_BIT] && !ctl_ff[CTL_SUSP_CLK_BIT];
    nxt_xcvr = ctl_ff[CTL_ENABLE_BIT];
    nxt_crst = !ctl_ff[CTL_ENABLE_BIT];
    nxt_wreq = ctl_ff[CTL_RWU_SEND_BIT];
    nxt_drv = (rs_ff == RS_DRIVE);
    nxt_addr = ctl_ff[CTL_ADDR_EN_BIT] ? bus.prog_addr : DEFAULT_ADDR;
  end

  // Register stage.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_ff <= CTL_RESET;
      susp_cnt_ff <= '0;
      se0_cnt_ff <= '0;
      drv_cnt_ff <= '0;
      rs_ff <= RS_IDLE;
      wake_ff <= 1'b0;
      bus_rst_ff <= 1'b0;
      vref_ff <= 1'b1;
      clk_en_ff <= 1'b0;
      xcvr_ff <= 1'b0;
      crst_ff <= 1'b1;
      wreq_ff <= 1'b0;
      drv_ff <= 1'b0;
      addr_ff <= ADDR_RESET;
    end else begin
      ctl_ff <= nxt_ctl;
      susp_cnt_ff <= nxt_susp_cnt;
      se0_cnt_ff <= nxt_se0_cnt;
      drv_cnt_ff <= nxt_drv_cnt;
      rs_ff <= nxt_rs;
      wake_ff <= nxt_wake;
      bus_rst_ff <= nxt_bus_rst;
      vref_ff <= nxt_vref;
      clk_en_ff <= nxt_clk_en;
      xcvr_ff <= nxt_xcvr;
      crst_ff <= nxt_crst;
      wreq_ff <= nxt_wreq;
      drv_ff <= nxt_drv;
      addr_ff <= nxt_addr;
    end
  end

  // Outputs other than vref_o come straight from flip-flops; vref level is a constant 1, enable low floats it.
  assign bus.rd_data = ctl_ff;
  assign bus.wake_cpu = wake_ff;
  assign vref_o = 1'b1;
  assign vref_oe_o = vref_ff;
  assign ctrl_clk_en_o = clk_en_ff;
  assign xcvr_en_o = xcvr_ff;
  assign ctrl_rst_o = crst_ff;
  assign wake_req_o = wreq_ff;
  assign resume_drive_o = drv_ff;
  assign func_addr_o = addr_ff;
endmodule
`default_nettype wire

// ===== design/ugc_firmware.sv
// Firmware end: turns simple user commands into control register writes.
// Assumes the device end answers over ugc_if on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ugc_firmware
  import ugc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  ugc_if.fw bus,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic set_config_i,
  input wire logic [7:0] config_value_i,
  input wire logic set_addr_done_i,
  input wire logic [6:0] addr_i,
  input wire logic host_rwu_feature_i,
  input wire logic wake_ack_i,
  output logic [7:0] status_o,
  output logic wake_cpu_o
);
  import ugc_pkg::*;

  logic wr_ff, nxt_wr;
  logic [7:0] data_ff, nxt_data;
  logic clr_ff, nxt_clr;
  logic [6:0] addr_ff, nxt_addr;
  logic [7:0] stat_ff, nxt_stat;
  logic wake_ff, nxt_wake;
  logic [7:0] base;

  // Build one write per cycle from the read-back value and the commands.
  always_comb begin
    base = bus.rd_data;
    nxt_wr = 1'b0;
    nxt_data = data_ff;
    nxt_addr = addr_ff;
    if (cmd_write_i) begin
      nxt_wr = 1'b1;
      nxt_data = cmd_data_i;
    end else if (set_config_i) begin
      nxt_wr = 1'b1;
      nxt_data = base;
      nxt_data[CTL_CONFIGURED_BIT] = (config_value_i != 8'h00);
    end else if (set_addr_done_i) begin
      nxt_wr = 1'b1;
      nxt_data = base;
      nxt_data[CTL_ADDR_EN_BIT] = 1'b1;
      nxt_addr = addr_i;
    end
    // Address enable is never cleared from here, and wake enable is kept only while the host allows it.
    if (nxt_wr) begin
      nxt_data[CTL_ADDR_EN_BIT] = nxt_data[CTL_ADDR_EN_BIT] | base[CTL_ADDR_EN_BIT];
      nxt_data[CTL_RWU_ENABLE_BIT] = nxt_data[CTL_RWU_ENABLE_BIT] & host_rwu_feature_i;
    end
    // Wake flag is cleared only once clocks are back on.
    nxt_clr = wake_ack_i && bus.rd_data[CTL_ENABLE_BIT]
      && !bus.rd_data[CTL_SUSP_CLK_BIT];
    nxt_stat = bus.rd_data;
    nxt_wake = bus.wake_cpu;
  end

  // Register stage.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ff <= 1'b0;
      data_ff <= CTL_RESET;
      clr_ff <= 1'b0;
      addr_ff <= ADDR_RESET;
      stat_ff <= CTL_RESET;
      wake_ff <= 1'b0;
    end else begin
      wr_ff <= nxt_wr;
      data_ff <= nxt_data;
      clr_ff <= nxt_clr;
      addr_ff <= nxt_addr;
      stat_ff <= nxt_stat;
      wake_ff <= nxt_wake;
    end
  end

  assign bus.wr_en = wr_ff;
  assign bus.wr_data = data_ff;
  assign bus.wake_clr = clr_ff;
  assign bus.prog_addr = addr_ff;
  assign status_o = stat_ff;
  assign wake_cpu_o = wake_ff;
endmodule
`default_nettype wire

// ===== tb/ugc_monitor.sv
// Checker for the control register traffic between the two ends.
// Assumes one clock; the bench instantiates it beside the interface.
`timescale 1ns/1ps
`default_nettype none
module ugc_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic wake_cpu,
  input wire logic wake_clr,
  input wire logic [6:0] prog_addr
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Firmware bits 7:4 and 2 of a write show in the register one cycle later.
  property p_write;
    wr_en |=> {rd_data[7:4], rd_data[2]} == $past({wr_data[7:4], wr_data[2]});
  endproperty
  a_write: assert property (p_write) else $error("write not taken");
  // The send bit holds until firmware writes again.
  property p_send_hold;
    rd_data[5] && !wr_en |=> rd_data[5];
  endproperty
  a_send_hold: assert property (p_send_hold) else $error("send bit lost");
  // Send with wake enable raises the resume status quickly.
  property p_up_set;
    $rose(rd_data[5] && rd_data[2]) && rd_data[7] |-> ##[1:2] rd_data[3];
  endproperty
  a_up_set: assert property (p_up_set) else $error("resume status not set");
  // A write cannot set the resume status by itself.
  property p_up_ro;
    wr_en && !(rd_data[5] && rd_data[2]) && !rd_data[3] |=> !rd_data[3];
  endproperty
  a_up_ro: assert property (p_up_ro) else $error("resume status written");
  // A disabled controller keeps no resume status.
  property p_en_clear;
    !rd_data[7] && $past(!rd_data[7]) |-> !rd_data[3];
  endproperty
  a_en_clear: assert property (p_en_clear) else $error("status kept while off");
  // Firmware never writes the address enable back to zero.
  property p_addr_or;
    wr_en && rd_data[0] |-> wr_data[0];
  endproperty
  a_addr_or: assert property (p_addr_or) else $error("address enable cleared");
  // The wake flag is cleared only with all clocks running.
  property p_clr_ok;
    wake_clr |-> rd_data[7] && !rd_data[6];
  endproperty
  a_clr_ok: assert property (p_clr_ok) else $error("clear while gated");
  // The wake flag holds until a clear strobe.
  property p_wake_hold;
    wake_cpu && !wake_clr |=> wake_cpu;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake flag lost");
  // The programmed address moves only together with a write strobe.
  property p_addr_stable;
    !wr_en |-> $stable(prog_addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved alone");
  // Main scenarios reached.
  c_write: cover property (wr_en);
  c_wake_clr: cover property (wake_clr);
  c_up: cover property ($rose(rd_data[3]));
  c_cfg_clr: cover property ($fell(rd_data[1]));
endmodule
`default_nettype wire

// ===== tb/test_usb_global_control_bits.sv
// Bench joining firmware end and device end through the interface.
// Assumes the design package and interface are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_usb_global_control_bits;
  import ugc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_write = 1'b0, set_config = 1'b0, set_addr = 1'b0, rwu_ok = 1'b0;
  logic se0 = 1'b0, idle = 1'b0, wake_ack = 1'b0;
  logic [7:0] cmd_data = 8'h00, cfg_val = 8'h00, status;
  logic [6:0] addr = 7'h2a, faddr;
  logic wake_o, vref, vref_oe, clk_en, xcvr, crst, wreq, rdrv;
  int mismatches = 0, checks_done = 0, cycles = 0;
  ugc_if i_ugc_if();
  ugc_firmware i_ugc_firmware (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(i_ugc_if),
    .cmd_write_i(cmd_write), .cmd_data_i(cmd_data), .set_config_i(set_config),
    .config_value_i(cfg_val), .set_addr_done_i(set_addr), .addr_i(addr),
    .host_rwu_feature_i(rwu_ok), .wake_ack_i(wake_ack), .status_o(status), .wake_cpu_o(wake_o));
  ugc_device i_ugc_device (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(i_ugc_if),
    .line_se0_i(se0), .line_idle_i(idle), .vref_o(vref), .vref_oe_o(vref_oe),
    .ctrl_clk_en_o(clk_en), .xcvr_en_o(xcvr), .ctrl_rst_o(crst), .wake_req_o(wreq),
    .resume_drive_o(rdrv), .func_addr_o(faddr));
  ugc_monitor i_ugc_monitor (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wr_en(i_ugc_if.wr_en),
    .wr_data(i_ugc_if.wr_data), .rd_data(i_ugc_if.rd_data), .wake_cpu(i_ugc_if.wake_cpu),
    .wake_clr(i_ugc_if.wake_clr), .prog_addr(i_ugc_if.prog_addr));
  // Clock generator, 10 ns period.
  always #5 ref_clk_i = ~ref_clk_i;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard; the run needs under 4000 cycles.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // One-cycle pulse on a firmware command input, then settle.
  task automatic cmd(input logic [7:0] d);
    cmd_data = d;
    cmd_write = 1'b1;
    ticks(1);
    cmd_write = 1'b0;
    ticks(5);
  endtask
  task automatic cfg(input logic [7:0] v);
    cfg_val = v;
    set_config = 1'b1;
    ticks(1);
    set_config = 1'b0;
    ticks(5);
  endtask
  task automatic se0_for(input int n);
    se0 = 1'b1;
    ticks(n);
    se0 = 1'b0;
    ticks(10);
  endtask
  // Wake acknowledge pulse; the clear strobe stands one cycle, looked at while it stands.
  task automatic ack(input logic exp);
    wake_ack = 1'b1;
    ticks(1);
    chk({7'h0, i_ugc_if.wake_clr}, {7'h0, exp});
    wake_ack = 1'b0;
    ticks(2);
    chk({7'h0, i_ugc_if.wake_clr}, 8'h00);
  endtask
  task automatic t_enable();
    chk({6'h0, vref, vref_oe}, 8'h03);
    chk({5'h0, clk_en, xcvr, crst}, 8'h01);
    cmd(8'h88);
    chk(status, 8'h80);
    chk({5'h0, clk_en, xcvr, crst}, 8'h06);
    cmd(8'hc0);
    chk({7'h0, clk_en}, 8'h00);
    ack(1'b0);
    cmd(8'h90);
    chk({7'h0, vref_oe}, 8'h00);
    cmd(8'h80);
    chk({7'h0, vref_oe}, 8'h01);
  endtask
  task automatic t_config();
    cfg(8'h05);
    chk(status, 8'h82);
    chk({1'b0, faddr}, {1'b0, DEFAULT_ADDR});
    set_addr = 1'b1;
    ticks(1);
    set_addr = 1'b0;
    ticks(5);
    chk({1'b0, faddr}, 8'h2a);
    cfg(8'h00);
    chk(status, 8'h81);
    cmd(8'h82);
    chk(status, 8'h83);
  endtask
  task automatic t_bus_reset();
    se0_for(200);
    chk(status, 8'h83);
    se0_for(300);
    chk(status, 8'h80);
    chk({1'b0, faddr}, {1'b0, DEFAULT_ADDR});
  endtask
  task automatic t_resume();
    cmd(8'ha4);
    chk(status, 8'ha0);
    chk({7'h0, wreq}, 8'h01);
    cmd(8'h80);
    chk({7'h0, wreq}, 8'h00);
    rwu_ok = 1'b1;
    cmd(8'ha4);
    chk(status, 8'hac);
    ack(1'b1);
    idle = 1'b1;
    ticks(2000);
    chk({7'h0, rdrv}, 8'h00);
    idle = 1'b0;
    ticks(10);
    chk({7'h0, wake_o}, 8'h00);
    cmd(8'h00);
    chk(status, 8'h00);
  endtask
  // Reset, then the scenarios in order.
  initial begin
    ticks(4);
    rst_i = 1'b0;
    ticks(1);
    t_enable();
    t_config();
    t_bus_reset();
    t_resume();
    print_verdict();
  end
endmodule
`default_nettype wire
